// [rtl/nes_seq.sv]
// External program sequencer of the nonvolatile memory controller.
// Assumes an APB master, a debug-port controller that holds each access
// until acknowledged, and a memory array that runs operations to op_done.
//
// Operation
// - 0x2D erases then writes a boot page on debug write, busy held.
// - 0x39 boot section CRC, protected, execute bit, busy until checksum.
// - 0x01 and 0x02 read signature rows on debug read, no busy.
// - 0x18 erases, 0x1A writes user signature on debug write, busy held.
// - 0x06 and 0x07 read like generic read, no busy.
// - Fuses written by 0x4C debug write; locks by protected 0x08 execute.
// - 0x33 loads EEPROM buffer byte; 0x36 clears buffer with busy.
// - 0x32, 0x34, 0x35 EEPROM page erase, write, both; busy held.
// - Section erases by execute bit; 0x30 EEPROM is protected, busy.
// - Preserve fuse programmed keeps EEPROM through chip erase.
// - Chip erase clears flash and locks, keeps signatures and fuses.
// - Chip erase cuts debug bus and clears link flag until done.
// - Low byte held in temp, stored with high byte in one cycle.
// - Debug port stalled after a buffer load until it completes.
// - Page write via debug write to any byte in the page.
// - Erase-and-write page runs as one uninterrupted operation.
// - Single-page erase by execute bit too, busy until done.
// - Flash CRC ignores locks, cuts debug bus, clears link flag.
// - CRC result lands in the data register when busy clears.
// - Buffer erase keeps busy until the clear has finished.
// - Execute bit, debug read and debug write trigger their commands.
// - Read and write lock leave only chip erase and flash CRC.
// - Memory reads blocked while busy.
`timescale 1ns/1ps
module nes_seq #(
  parameter int FBUF_WORDS = 64,
  parameter int EBUF_BYTES = 32
) (
  input  wire logic              mclk_in,
  input  wire logic              nrst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              dbg_req_in,
  input  wire nes_pkg::nes_dbg_t dbg_cmd_in,
  output logic                   dbg_ack_out,
  output logic                   dbg_err_out,
  output logic [7:0]             dbg_rdata_out,
  output logic                   link_enabled_out,
  output logic                   busy_out,
  input  wire logic              lock_rw_in,
  input  wire logic              eeprom_preserve_fuse_in,
  input  wire logic              ext_prog_in,
  input  wire logic              cp_open_in,
  output logic                   op_valid_out,
  output nes_pkg::nes_op_t       op_out,
  input  wire logic              op_done_in,
  input  wire logic              crc_valid_in,
  input  wire logic [15:0]       crc_data_in,
  output logic                   mem_rd_out,
  input  wire logic              mem_rd_ack_in,
  input  wire logic [7:0]        mem_rd_data_in,
  input  wire logic [7:0]        pbuf_idx_in,
  output logic [15:0]            fbuf_word_out,
  output logic [7:0]             ebuf_byte_out,
  output logic                   ebuf_tag_out
);
  localparam int FIW = $clog2(FBUF_WORDS);
  localparam int EIW = $clog2(EBUF_BYTES);

  // ==========================================================
  // Command classification
  function automatic logic is_exec(input logic [6:0] c);
    unique case (c)
      nes_pkg::C_CHIPER, nes_pkg::C_ERFB, nes_pkg::C_FCRC,
      nes_pkg::C_ACRC, nes_pkg::C_BCRC, nes_pkg::C_WRLOCK,
      nes_pkg::C_EREB, nes_pkg::C_EREE, nes_pkg::C_ERAPP,
      nes_pkg::C_ERBOOT, nes_pkg::C_ERAPG, nes_pkg::C_ERBPG,
      nes_pkg::C_ERUSIG, nes_pkg::C_EREPG: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic is_prot(input logic [6:0] c);
    unique case (c)
      nes_pkg::C_CHIPER, nes_pkg::C_ERFB, nes_pkg::C_FCRC,
      nes_pkg::C_ACRC, nes_pkg::C_BCRC, nes_pkg::C_WRLOCK,
      nes_pkg::C_EREB, nes_pkg::C_EREE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic is_wr(input logic [6:0] c);
    unique case (c)
      nes_pkg::C_ERFP, nes_pkg::C_WRFP, nes_pkg::C_EWFP,
      nes_pkg::C_ERAPP, nes_pkg::C_ERAPG, nes_pkg::C_WRAPG,
      nes_pkg::C_EWAPG, nes_pkg::C_ERBOOT, nes_pkg::C_ERBPG,
      nes_pkg::C_WRBPG, nes_pkg::C_EWBPG, nes_pkg::C_ERUSIG,
      nes_pkg::C_WRUSIG, nes_pkg::C_WRFUSE, nes_pkg::C_EREPG,
      nes_pkg::C_WREPG, nes_pkg::C_EWEPG: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic is_rd(input logic [6:0] c);
    unique case (c)
      nes_pkg::C_RDNVM, nes_pkg::C_RDUSIG, nes_pkg::C_RDPSIG,
      nes_pkg::C_RDFUSE, nes_pkg::C_RDEE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic is_crc(input logic [6:0] c);
    return (c == nes_pkg::C_FCRC) || (c == nes_pkg::C_ACRC) ||
           (c == nes_pkg::C_BCRC);
  endfunction
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [15:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 15; i >= 0; i--)
    begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ nes_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ==========================================================
  // State
  nes_pkg::nes_state_t state_r;
  nes_pkg::nes_state_t state_nxt;
  logic [6:0]          cmd_r;
  logic [23:0]         addr_r;
  logic [31:0]         data_r;
  logic [31:0]         crc_r;
  logic                refused_r;
  logic                link_r;
  logic                busy_r;
  logic                opv_r;
  logic [7:0]          clr_cnt_r;
  logic [7:0]          lo_tmp_r;
  logic [15:0]         fbuf_r [FBUF_WORDS];
  logic [7:0]          ebuf_r [EBUF_BYTES];
  logic [EBUF_BYTES-1:0] etag_r;
  logic                ack_r;
  logic                err_r;
  logic [7:0]          rdata_r;
  nes_pkg::nes_op_t    op_r;
  logic                rd_r;
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                perr_r;

  // ==========================================================
  // APB decode
  wire         apb_setup = psel_in & ~penable_in;
  wire         apb_acc   = psel_in & penable_in & pready_r;
  wire         apb_wr    = apb_acc & pwrite_in;
  wire         hit_cmd   = paddr_in == nes_pkg::OFF_CMD;
  wire         hit_ctrl  = paddr_in == nes_pkg::OFF_NVM_CONTROL_A;
  wire         hit_stat  = paddr_in == nes_pkg::OFF_STATUS;
  wire         hit_data  = paddr_in == nes_pkg::OFF_DATA;
  wire         hit_addr  = paddr_in == nes_pkg::OFF_ADDR;
  wire         hit_any   = hit_cmd | hit_ctrl | hit_stat | hit_data | hit_addr;
  wire [31:0]  stat_word = {29'h0, refused_r, link_r, busy_r};
  wire [31:0]  rd_mux    = hit_cmd  ? {25'h0, cmd_r} :
                           hit_stat ? stat_word :
                           hit_data ? data_r :
                           hit_addr ? {8'h0, addr_r} : 32'h0000_0000;

  // ==========================================================
  // Trigger qualification
  wire idle      = state_r == nes_pkg::S_IDLE;
  wire lock_ok   = ~lock_rw_in | (cmd_r == nes_pkg::C_CHIPER) |
                   (cmd_r == nes_pkg::C_FCRC);
  wire prot_ok   = ~is_prot(cmd_r) | ext_prog_in | cp_open_in;
  wire exec_try  = apb_wr & hit_ctrl & pwdata_in[nes_pkg::EXEC_BIT];
  wire exec_ok   = exec_try & idle & is_exec(cmd_r) & lock_ok & prot_ok;
  wire dbg_new   = dbg_req_in & ~ack_r & ~rd_r;
  wire dbg_busy  = dbg_new & (busy_r | ~link_r);
  wire dbg_go    = dbg_new & idle & link_r & ~exec_ok;
  wire dbg_w     = dbg_go & dbg_cmd_in.we;
  wire dbg_rd_ok = dbg_go & ~dbg_cmd_in.we & is_rd(cmd_r) & lock_ok;
  wire dbg_wr_ok = dbg_w & is_wr(cmd_r) & lock_ok;
  wire ld_fb     = dbg_w & (cmd_r == nes_pkg::C_LDFB) & lock_ok;
  wire ld_eb     = dbg_w & (cmd_r == nes_pkg::C_LDEB) & lock_ok;
  wire dbg_bad   = dbg_go & ~dbg_rd_ok & ~dbg_wr_ok & ~ld_fb & ~ld_eb;
  wire op_start  = (exec_ok & (cmd_r != nes_pkg::C_ERFB) &
                   (cmd_r != nes_pkg::C_EREB)) | dbg_wr_ok;
  wire bclr_go   = exec_ok & ((cmd_r == nes_pkg::C_ERFB) |
                   (cmd_r == nes_pkg::C_EREB));
  wire refuse    = (exec_try & ~exec_ok) | dbg_busy | dbg_bad;
  wire link_cut  = (cmd_r == nes_pkg::C_CHIPER) |
                   (cmd_r == nes_pkg::C_FCRC);
  wire [7:0] clr_last = (cmd_r == nes_pkg::C_ERFB) ?
                        8'(FBUF_WORDS - 1) : 8'(EBUF_BYTES - 1);
  wire clr_done  = (state_r == nes_pkg::S_BCLR) & (clr_cnt_r == clr_last);
  wire arr_done  = (state_r == nes_pkg::S_ARRAY) & op_done_in;
  wire [31:0] crc_nxt = (crc_valid_in & (state_r == nes_pkg::S_ARRAY)) ?
                        crc_step(crc_r, crc_data_in) : crc_r;
  wire [FIW-1:0] fidx = dbg_cmd_in.addr[FIW:1];
  wire [EIW-1:0] eidx = dbg_cmd_in.addr[EIW-1:0];
  wire [23:0] op_addr = exec_ok ? addr_r : dbg_cmd_in.addr;
  wire [7:0]  op_data = exec_ok ? data_r[7:0] : dbg_cmd_in.wdata;

  // Next state of the sequencer
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      nes_pkg::S_IDLE:
      begin
        if (op_start)
          state_nxt = nes_pkg::S_ARRAY;
        else if (bclr_go)
          state_nxt = nes_pkg::S_BCLR;
        else if (dbg_rd_ok)
          state_nxt = nes_pkg::S_READ;
        else if (ld_fb | ld_eb)
          state_nxt = nes_pkg::S_LOAD;
      end
      nes_pkg::S_ARRAY: if (op_done_in) state_nxt = nes_pkg::S_IDLE;
      nes_pkg::S_BCLR:  if (clr_done) state_nxt = nes_pkg::S_IDLE;
      nes_pkg::S_READ:  if (mem_rd_ack_in) state_nxt = nes_pkg::S_IDLE;
      nes_pkg::S_LOAD:  state_nxt = nes_pkg::S_IDLE;
      default:          state_nxt = nes_pkg::S_IDLE;
    endcase
  end

  // ==========================================================
  // APB slave, zero wait states
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      perr_r   <= 1'b0;
    end
    else
    begin
      pready_r <= apb_setup;
      perr_r   <= apb_setup & ~hit_any;
      prdata_r <= apb_setup ? rd_mux : 32'h0000_0000;
    end
  end

  // Software registers; a refusal in the clearing cycle still sticks
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cmd_r     <= nes_pkg::CMD_RST;
      addr_r    <= nes_pkg::ADDR_RST;
      refused_r <= 1'b0;
    end
    else
    begin
      if (apb_wr & hit_cmd & ~busy_r)
        cmd_r <= pwdata_in[6:0];
      if (apb_wr & hit_addr & ~busy_r)
        addr_r <= pwdata_in[23:0];
      if (refuse)
        refused_r <= 1'b1;
      else if (apb_wr & hit_cmd)
        refused_r <= 1'b0;
    end
  end

  // Sequencer, busy and link flag
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r   <= nes_pkg::S_IDLE;
      busy_r    <= 1'b0;
      link_r    <= 1'b1;
      opv_r     <= 1'b0;
      clr_cnt_r <= 8'h00;
    end
    else
    begin
      state_r   <= state_nxt;
      opv_r     <= state_nxt == nes_pkg::S_ARRAY;
      busy_r    <= (state_nxt == nes_pkg::S_ARRAY) |
                   (state_nxt == nes_pkg::S_BCLR);
      if (op_start)
        link_r <= ~link_cut;
      else if (arr_done)
        link_r <= 1'b1;
      clr_cnt_r <= (state_r == nes_pkg::S_BCLR) ? clr_cnt_r + 8'h01 : 8'h00;
    end
  end

  // Array operation and CRC accumulation
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      op_r   <= '0;
      crc_r  <= nes_pkg::CRC_INIT;
      data_r <= nes_pkg::DATA_RST;
    end
    else
    begin
      if (op_start)
      begin
        op_r.code    <= cmd_r;
        op_r.addr    <= op_addr;
        op_r.data    <= op_data;
        op_r.keep_ee <= eeprom_preserve_fuse_in;
        crc_r        <= nes_pkg::CRC_INIT;
      end
      else
        crc_r <= crc_nxt;
      if (arr_done & is_crc(op_r.code))
        data_r <= crc_nxt;
      else if (apb_wr & hit_data & ~busy_r)
        data_r <= pwdata_in;
    end
  end

  // Debug-port answers: read data, stall release, refusals
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ack_r   <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= 8'h00;
      rd_r    <= 1'b0;
    end
    else
    begin
      rd_r  <= dbg_rd_ok | (rd_r & ~mem_rd_ack_in);
      ack_r <= dbg_busy | dbg_bad | dbg_wr_ok | (rd_r & mem_rd_ack_in) |
               (state_r == nes_pkg::S_LOAD);
      err_r <= dbg_busy | dbg_bad;
      if (rd_r & mem_rd_ack_in)
        rdata_r <= mem_rd_data_in;
    end
  end

  // Page buffers, flash words assembled from low then high byte
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      lo_tmp_r <= 8'h00;
      etag_r   <= '0;
    end
    else
    begin
      if (ld_fb & ~dbg_cmd_in.addr[0])
        lo_tmp_r <= dbg_cmd_in.wdata;
      if (ld_eb)
        etag_r[eidx] <= 1'b1;
      if ((state_r == nes_pkg::S_BCLR) & (cmd_r == nes_pkg::C_EREB))
        etag_r[clr_cnt_r[EIW-1:0]] <= 1'b0;
    end
  end

  // Buffer storage has no reset; the clear walk fills it
  always_ff @(posedge mclk_in)
  begin
    if (ld_fb & dbg_cmd_in.addr[0])
      fbuf_r[fidx] <= {dbg_cmd_in.wdata, lo_tmp_r};
    else if ((state_r == nes_pkg::S_BCLR) & (cmd_r == nes_pkg::C_ERFB))
      fbuf_r[clr_cnt_r[FIW-1:0]] <= 16'hFFFF;
    if (ld_eb)
      ebuf_r[eidx] <= dbg_cmd_in.wdata;
    else if ((state_r == nes_pkg::S_BCLR) & (cmd_r == nes_pkg::C_EREB))
      ebuf_r[clr_cnt_r[EIW-1:0]] <= 8'hFF;
  end

  // Registered buffer read port for the array
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      fbuf_word_out <= 16'h0000;
      ebuf_byte_out <= 8'h00;
      ebuf_tag_out  <= 1'b0;
    end
    else
    begin
      fbuf_word_out <= fbuf_r[pbuf_idx_in[FIW-1:0]];
      ebuf_byte_out <= ebuf_r[pbuf_idx_in[EIW-1:0]];
      ebuf_tag_out  <= etag_r[pbuf_idx_in[EIW-1:0]];
    end
  end

  // ==========================================================
  // Output assignments
  assign prdata_out       = prdata_r;
  assign pready_out       = pready_r;
  assign pslverr_out      = perr_r;
  assign dbg_ack_out      = ack_r;
  assign dbg_err_out      = err_r;
  assign dbg_rdata_out    = rdata_r;
  assign link_enabled_out = link_r;
  assign busy_out         = busy_r;
  assign op_valid_out     = opv_r;
  assign op_out           = op_r;
  assign mem_rd_out       = rd_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  busy_hold_a: assert property ((state_r == nes_pkg::S_ARRAY) && !op_done_in
    |=> busy_r) else $error("busy dropped during operation");
  link_cut_a: assert property (op_start && link_cut |=> !link_r [*2]
    or (!link_r ##1 link_r)) else $error("link flag not cleared");
  lock_gate_a: assert property (lock_rw_in && op_start |->
    link_cut) else $error("locked command started");
  busy_ignore_a: assert property (busy_r && exec_try |=> refused_r &&
    $stable(op_r)) else $error("trigger taken while busy");
  rd_nobusy_a: assert property (dbg_rd_ok |=> !busy_r && rd_r)
    else $error("read set busy");
  load_stall_a: assert property ((ld_fb || ld_eb) |=> !ack_r ##1 ack_r)
    else $error("load stall wrong");
  word_pair_a: assert property (ld_fb && dbg_cmd_in.addr[0] |=>
    fbuf_r[$past(fidx)] == {$past(dbg_cmd_in.wdata), $past(lo_tmp_r)})
    else $error("word not paired");
  crc_result_a: assert property (arr_done && is_crc(op_r.code) |=>
    data_r == $past(crc_nxt) && !busy_r) else $error("checksum lost");
  rd_block_a: assert property (dbg_new && busy_r |=> ack_r && err_r)
    else $error("read not blocked");
  bclr_busy_a: assert property (bclr_go |=> busy_r throughout
    (state_r == nes_pkg::S_BCLR)[*8]) else $error("clear not busy");
  keep_ee_a: assert property (op_start |=> op_r.keep_ee ==
    $past(eeprom_preserve_fuse_in)) else $error("preserve fuse lost");

  chip_erase_c: cover property (op_start && cmd_r == nes_pkg::C_CHIPER);
  crc_done_c:   cover property (arr_done && is_crc(op_r.code));
  pair_c:       cover property (ld_fb ##[1:20] ld_fb);
  page_wr_c:    cover property (dbg_wr_ok && cmd_r == nes_pkg::C_EWBPG);
endmodule

// [rtl/nes_pkg.sv]
// Shared constants and types of the external program sequencer.
// Assumes one system clock and an APB master for the control registers.
package nes_pkg;
  // ==========================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_NVM_CONTROL_A  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DATA   = 8'h0C;
  localparam logic [7:0] OFF_ADDR   = 8'h10;
  // Field positions
  localparam int EXEC_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int LINK_BIT = 1;
  localparam int REF_BIT  = 2;
  // Reset values
  localparam logic [6:0]  CMD_RST  = 7'h00;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [23:0] ADDR_RST = 24'h00_0000;
  // ==========================================================
  // Command codes
  localparam logic [6:0] C_NOP    = 7'h00;
  localparam logic [6:0] C_CHIPER = 7'h40;
  localparam logic [6:0] C_RDNVM  = 7'h43;
  localparam logic [6:0] C_LDFB   = 7'h23;
  localparam logic [6:0] C_ERFB   = 7'h26;
  localparam logic [6:0] C_ERFP   = 7'h2B;
  localparam logic [6:0] C_WRFP   = 7'h2E;
  localparam logic [6:0] C_EWFP   = 7'h2F;
  localparam logic [6:0] C_FCRC   = 7'h78;
  localparam logic [6:0] C_ERAPP  = 7'h20;
  localparam logic [6:0] C_ERAPG  = 7'h22;
  localparam logic [6:0] C_WRAPG  = 7'h24;
  localparam logic [6:0] C_EWAPG  = 7'h25;
  localparam logic [6:0] C_ACRC   = 7'h38;
  localparam logic [6:0] C_ERBOOT = 7'h68;
  localparam logic [6:0] C_ERBPG  = 7'h2A;
  localparam logic [6:0] C_WRBPG  = 7'h2C;
  localparam logic [6:0] C_EWBPG  = 7'h2D;
  localparam logic [6:0] C_BCRC   = 7'h39;
  localparam logic [6:0] C_RDUSIG = 7'h01;
  localparam logic [6:0] C_ERUSIG = 7'h18;
  localparam logic [6:0] C_WRUSIG = 7'h1A;
  localparam logic [6:0] C_RDPSIG = 7'h02;
  localparam logic [6:0] C_RDFUSE = 7'h07;
  localparam logic [6:0] C_WRFUSE = 7'h4C;
  localparam logic [6:0] C_WRLOCK = 7'h08;
  localparam logic [6:0] C_LDEB   = 7'h33;
  localparam logic [6:0] C_EREB   = 7'h36;
  localparam logic [6:0] C_EREE   = 7'h30;
  localparam logic [6:0] C_EREPG  = 7'h32;
  localparam logic [6:0] C_WREPG  = 7'h34;
  localparam logic [6:0] C_EWEPG  = 7'h35;
  localparam logic [6:0] C_RDEE   = 7'h06;
  // CRC setup
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ARRAY = 3'b001,
    S_BCLR  = 3'b010,
    S_READ  = 3'b011,
    S_LOAD  = 3'b100
  } nes_state_t;
  // Debug-port access as presented by the port controller
  typedef struct packed {
    logic        we;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } nes_dbg_t;
  // Operation handed to the memory array
  typedef struct packed {
    logic [6:0]  code;
    logic [23:0] addr;
    logic [7:0]  data;
    logic        keep_ee;
  } nes_op_t;
endpackage

// [verification/nes_mem_model.sv]
// Behavioural model of the memory array behind the sequencer.
// Assumes one clock and async low reset; answers reads and runs ops.
`timescale 1ns/1ps
module nes_mem_model #(
  parameter int          OP_CYCLES = 6,
  parameter logic [15:0] CRC_WORD  = 16'hC3A5,
  parameter logic [7:0]  RD_BYTE   = 8'h5A
) (
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  input  wire logic             op_valid_out,
  input  wire nes_pkg::nes_op_t op_out,
  input  wire logic             mem_rd_out,
  output logic                  op_done_in,
  output logic                  crc_valid_in,
  output logic [15:0]           crc_data_in,
  output logic                  mem_rd_ack_in,
  output logic [7:0]            mem_rd_data_in
);
  // ==========
  // Op timing
  int   cnt;
  logic is_crc;
  assign is_crc = op_out.code inside {nes_pkg::C_ACRC, nes_pkg::C_BCRC, nes_pkg::C_FCRC};
  // Runs each op to the full count; data lines toggle when not valid
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cnt           <= 0;
      op_done_in    <= 1'b0;
      crc_valid_in  <= 1'b0;
      mem_rd_ack_in <= 1'b0;
    end
    else
    begin
      cnt           <= (op_valid_out && !op_done_in) ? cnt + 1 : 0;
      op_done_in    <= op_valid_out && !op_done_in && cnt == OP_CYCLES - 1;
      crc_valid_in  <= op_valid_out && is_crc && cnt == 1;
      mem_rd_ack_in <= mem_rd_out && !mem_rd_ack_in;
      crc_data_in    <= (op_valid_out && is_crc && cnt == 1) ? CRC_WORD : ~crc_data_in;
      mem_rd_data_in <= (mem_rd_out && !mem_rd_ack_in) ? RD_BYTE : ~mem_rd_data_in;
    end
  end
endmodule

// [verification/nes_seq_tb_top.sv]
// Self-checking bench of the sequencer: APB and debug-port tasks.
// Assumes the array model answers every op and read.
`timescale 1ns/1ps
module nes_seq_tb_top;
  logic        mclk_in, nrst_in, psel_in, penable_in, pwrite_in, dbg_req_in, pe;
  logic        lock_rw_in, eeprom_preserve_fuse_in, ext_prog_in, cp_open_in;
  logic        pready_out, pslverr_out, dbg_ack_out, dbg_err_out, link_enabled_out;
  logic        busy_out, op_valid_out, op_done_in, crc_valid_in, mem_rd_out;
  logic        mem_rd_ack_in, ebuf_tag_out, de, db, lk, ke;
  logic [6:0]  dc;
  logic [7:0]  paddr_in, dbg_rdata_out, mem_rd_data_in, pbuf_idx_in, ebuf_byte_out;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [15:0] crc_data_in, fbuf_word_out;
  nes_pkg::nes_dbg_t dbg_cmd_in;
  nes_pkg::nes_op_t  op_out;
  int          fails, cmp_count, n, bcnt;
  logic [6:0]  rc [5] = '{7'h01, 7'h02, 7'h06, 7'h07, 7'h43};
  logic [6:0]  wc [17] = '{7'h2D, 7'h18, 7'h1A, 7'h4C, 7'h32, 7'h34, 7'h35, 7'h2E, 7'h2B,
                           7'h2F, 7'h20, 7'h22, 7'h24, 7'h25, 7'h2C, 7'h2A, 7'h68};
  logic [6:0]  ec [13] = '{7'h39, 7'h78, 7'h40, 7'h26, 7'h36, 7'h30, 7'h2A, 7'h68,
                           7'h38, 7'h20, 7'h22, 7'h18, 7'h32};
  int          mn [13] = '{1, 1, 1, 64, 32, 1, 1, 1, 1, 1, 1, 1, 1};
  // ==========
  // Design, array model and clock
  nes_seq #(.FBUF_WORDS(64), .EBUF_BYTES(32)) u_nes_seq (.*);
  nes_mem_model #(.OP_CYCLES(12), .CRC_WORD(16'hC3A5)) u_nes_mem_model (.*);
  always #25 mclk_in = ~mclk_in;
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hang(input int k, input int lim);
    if (k >= lim)
    begin
      fails++;
      tally_and_finish;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel_in    <= 1'b1;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk_in);
      if (pready_out === 1'b1) break;
    end
    rd = prdata_out;
    pe = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    hang(n, 20);
  endtask
  task automatic dbg(input logic w, input logic [23:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    dbg_req_in <= 1'b1;
    dbg_cmd_in <= {w, a, d};
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk_in);
      if (dbg_ack_out === 1'b1) break;
    end
    {de, db, dc} = {dbg_err_out, busy_out, op_out.code};
    dbg_req_in <= 1'b0;
    hang(n, 50);
  endtask
  // Waits for busy to clear, counting busy cycles and link drops
  task automatic idle;
    {bcnt, lk} = 0;
    for (n = 0; n < 300; n++)
    begin
      @(posedge mclk_in);
      if (busy_out !== 1'b1 && n >= 3) break;
      if (busy_out === 1'b1) bcnt++;
      if (busy_out === 1'b1 && link_enabled_out === 1'b0) lk = 1'b1;
      if (op_valid_out === 1'b1) ke = op_out.keep_ee;
    end
    hang(n, 300);
  endtask
  task automatic exec(input logic [6:0] c);
    apb(1'b1, nes_pkg::OFF_CMD, {25'h0, c});
    apb(1'b1, nes_pkg::OFF_NVM_CONTROL_A, 32'h0000_0001);
    idle;
  endtask
  function automatic logic [31:0] crc_exp(input logic [15:0] d);
    logic [31:0] c;
    c = nes_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = (c << 1) ^ ((c[31] ^ d[i]) ? nes_pkg::CRC_POLY : 32'h0);
    return c;
  endfunction
  // ==========
  // Test sequence
  initial
  begin
    {mclk_in, nrst_in, psel_in, penable_in, pwrite_in, dbg_req_in, cp_open_in} = 0;
    {lock_rw_in, paddr_in, pwdata_in, dbg_cmd_in, pbuf_idx_in} = 0;
    {eeprom_preserve_fuse_in, ext_prog_in} = 2'b11;
    repeat (8) @(posedge mclk_in);
    nrst_in <= 1'b1;
    apb(1'b0, nes_pkg::OFF_STATUS, 0);
    chk(rd, 32'h0000_0002);
    apb(1'b0, 8'h14, 0);
    chk(pe, 1'b1);
    $display("reset and map done");
    foreach (rc[i])
    begin
      apb(1'b1, nes_pkg::OFF_CMD, {25'h0, rc[i]});
      dbg(1'b0, 24'h00_1000 + 24'(i), 8'h00);
      chk({de, db, dbg_rdata_out}, {2'b00, 8'h5A});
    end
    foreach (wc[i])
    begin
      apb(1'b1, nes_pkg::OFF_CMD, {25'h0, wc[i]});
      dbg(1'b1, 24'h00_2041, 8'h3C);
      chk({de, db, dc}, {2'b01, wc[i]});
      chk({op_out.addr, op_out.data}, {24'h00_2041, 8'h3C});
      idle;
    end
    apb(1'b1, nes_pkg::OFF_CMD, {25'h0, nes_pkg::C_LDFB});
    dbg(1'b1, 24'h00_0010, 8'h11);
    dbg(1'b1, 24'h00_0011, 8'h22);
    pbuf_idx_in <= 8'h08;
    repeat (2) @(posedge mclk_in);
    chk({db, fbuf_word_out}, {1'b0, 16'h2211});
    apb(1'b1, nes_pkg::OFF_CMD, {25'h0, nes_pkg::C_LDEB});
    dbg(1'b1, 24'h00_0003, 8'h7E);
    pbuf_idx_in <= 8'h03;
    repeat (2) @(posedge mclk_in);
    chk({db, ebuf_tag_out, ebuf_byte_out}, {2'b01, 8'h7E});
    $display("debug-port commands done");
    foreach (ec[i])
    begin
      exec(ec[i]);
      chk({lk, bcnt >= mn[i]}, {ec[i] inside {7'h40, 7'h78}, 1'b1});
      apb(1'b0, nes_pkg::OFF_DATA, 0);
      if (ec[i] inside {7'h38, 7'h39, 7'h78}) chk(rd, crc_exp(16'hC3A5));
      if (ec[i] == 7'h40) chk(ke, 1'b1);
    end
    $display("execute commands done");
    apb(1'b1, nes_pkg::OFF_CMD, {25'h0, nes_pkg::C_WRFP});
    dbg(1'b1, 24'h00_2000, 8'h00);
    apb(1'b1, nes_pkg::OFF_CMD, {25'h0, nes_pkg::C_RDNVM});
    apb(1'b1, nes_pkg::OFF_NVM_CONTROL_A, 32'h0000_0001);
    dbg(1'b0, 24'h00_2000, 8'h00);
    chk(de, 1'b1);
    idle;
    apb(1'b0, nes_pkg::OFF_CMD, 0);
    chk(rd[6:0], nes_pkg::C_WRFP);
    lock_rw_in <= 1'b1;
    exec(nes_pkg::C_EREB);
    apb(1'b0, nes_pkg::OFF_STATUS, 0);
    chk({bcnt == 0, rd[2]}, 2'b11);
    exec(nes_pkg::C_FCRC);
    chk(bcnt > 0, 1'b1);
    lock_rw_in  <= 1'b0;
    ext_prog_in <= 1'b0;
    exec(nes_pkg::C_WRLOCK);
    chk(bcnt, 0);
    cp_open_in <= 1'b1;
    exec(nes_pkg::C_BCRC);
    chk(bcnt > 0, 1'b1);
    {cp_open_in, ext_prog_in, eeprom_preserve_fuse_in} <= 3'b010;
    exec(nes_pkg::C_WRLOCK);
    chk(bcnt > 0, 1'b1);
    exec(nes_pkg::C_CHIPER);
    chk(ke, 1'b0);
    $display("refusals done");
    tally_and_finish;
  end
endmodule
